// >>> rtl/btsdma_core.v
// single channel byte transfer and search dma engine
// assumes an avalon-mm host on i_clk; system bus pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "btsdma_regs.vh"
// ======================================================
module btsdma_core #(
    parameter AW = 4                          // avalon word address width
) (
    input  wire          i_clk,               // system clock
    input  wire          i_srst,              // sync reset, high
    input  wire [AW-1:0] i_avs_address,       // register word address
    input  wire          i_avs_read,          // register read
    input  wire          i_avs_write,         // register write
    input  wire [31:0]   i_avs_writedata,     // write data
    output reg  [31:0]   o_avs_readdata,      // read data
    output wire          o_avs_waitrequest,   // stall host
    output wire [15:0]   o_addr,              // system address
    output wire          o_addr_oe,           // address drive enable
    input  wire [7:0]    i_data,              // system data in
    output wire [7:0]    o_data,              // system data out
    output wire          o_data_oe,           // data drive enable
    output wire          o_mem_request_n,     // memory request
    output wire          o_io_request_n,      // io request out
    output wire          o_rd_n,              // read strobe
    output wire          o_wr_n,              // write strobe
    output wire          o_ctl_oe,            // strobe drive enable
    input  wire          i_io_request_n,      // io request from cpu
    input  wire          i_opcode_fetch_cycle_n, // opcode fetch
    input  wire          i_rdy,               // port ready
    input  wire          i_wait_n,            // wait from port
    input  wire          i_bus_request_line,  // request line level
    output wire          o_bus_request_line_oe, // pull request low
    input  wire          i_bus_grant_in_n,    // grant in
    output wire          o_bus_grant_out_n,   // grant to lower dma
    input  wire          i_irq_chain_in,      // chain enable in
    output wire          o_irq_chain_out,     // chain enable out
    output wire          o_int_oe             // pull interrupt low
);
    localparam S_IDLE = 3'h0;
    localparam S_REQ  = 3'h1;
    localparam S_RD   = 3'h2;
    localparam S_WR   = 3'h3;
    localparam S_NXT  = 3'h4;
    localparam S_PAU  = 3'h5;
    localparam S_REL  = 3'h6;

    reg  [14:0] sy1_ff;
    reg  [14:0] sy2_ff;
    reg         acc_ff;
    reg  [7:0]  ctrl_ff;
    reg  [15:0] sa_ff;
    reg  [15:0] sb_ff;
    reg  [15:0] len_ff;
    reg  [7:0]  mbyte_ff;
    reg  [7:0]  mask_ff;
    reg  [17:0] tim_ff;
    reg  [23:0] intc_ff;
    reg  [15:0] ca_ff;
    reg  [15:0] cb_ff;
    reg  [15:0] cnt_ff;
    reg  [2:0]  st_ff;
    reg  [3:0]  tick_ff;
    reg  [7:0]  byte_ff;
    reg         en_ff;
    reg         breq_ff;
    reg         mst_ff;
    reg         eob_ff;
    reg         mat_ff;
    reg         cmp_ff;
    reg         ip_ff;
    reg         ius_ff;
    reg  [1:0]  cause_ff;
    reg         vdrv_ff;
    reg         ack_d_ff;
    reg         m1_d_ff;
    reg         ed_ff;
    reg  [7:0]  pcnt_ff;
    reg         pls_ff;

    // synchronised pins
    wire [7:0]  data_s = sy2_ff[7:0];
    wire        rdy_s  = sy2_ff[8];
    wire        bai_s  = sy2_ff[9];
    wire        brq_s  = sy2_ff[10];
    wire        m1_s   = sy2_ff[11];
    wire        io_request_s = sy2_ff[12];
    wire        iei_s  = sy2_ff[13];
    wire        wait_s = sy2_ff[14];

    // ======================================================
    // derived control
    wire        rdy_act = ctrl_ff[`BTS_C_RDHI] ? rdy_s : ~rdy_s;
    wire        atob    = ctrl_ff[`BTS_C_ATOB];
    wire        in_rd   = (st_ff == S_RD);
    wire        in_wr   = (st_ff == S_WR);
    wire [1:0]  cyf     = (in_rd == atob) ? tim_ff[`BTS_T_CYA] : tim_ff[`BTS_T_CYB];
    wire [3:0]  erl     = (in_rd == atob) ? tim_ff[`BTS_T_ERA] : tim_ff[`BTS_T_ERB];
    wire        pio     = (in_rd == atob) ? tim_ff[`BTS_T_IOA] : tim_ff[`BTS_T_IOB];
    // cycle of 2, 3 or 4 T, two clocks per T
    wire [3:0]  last    = (cyf == 2'h0) ? 4'h3 : (cyf == 2'h1) ? 4'h5 : 4'h7;
    wire        cyc_end = (in_rd | in_wr) & (tick_ff == last);
    wire        held    = (tick_ff == `BTS_WT_TK) & ~wait_s;
    wire        cmp_now = ((data_s ^ mbyte_ff) & ~mask_ff) == 8'h00;
    wire        eob_now = (cnt_ff == len_ff);
    wire        srch    = ctrl_ff[`BTS_C_SRCH];
    wire        xfer    = ctrl_ff[`BTS_C_XFER];
    wire        ack     = ~m1_s & ~io_request_s & ~mst_ff;
    wire        wr_ok   = i_avs_write & acc_ff & ~mst_ff;
    wire [7:0]  cmd     = i_avs_writedata[7:0];

    // strobe windows with optional half-T early end
    function on_win;
        input [3:0] tk;
        input [3:0] lst;
        input       early;
        input       first;
        begin
            on_win = (tk >= {3'h0, first}) && (tk < (early ? lst - 4'h1 : lst));
        end
    endfunction

    // address step per count rule
    function [15:0] step;
        input [15:0] a;
        input [1:0]  m;
        begin
            if (m == `BTS_A_FIX)
                step = a;
            else if (m == `BTS_A_INC)
                step = a + 16'h0001;
            else
                step = a - 16'h0001;
        end
    endfunction

    // ======================================================
    // pin drive
    wire [15:0] src_a = atob ? ca_ff : cb_ff;
    wire [15:0] dst_a = atob ? cb_ff : ca_ff;
    assign o_addr          = in_rd ? src_a : dst_a;
    assign o_addr_oe       = mst_ff;
    assign o_ctl_oe        = mst_ff;
    assign o_data          = vdrv_ff ? (intc_ff[`BTS_I_SAV] ?
                             {intc_ff[15:11], cause_ff, intc_ff[8]} :
                             intc_ff[`BTS_I_VEC]) : byte_ff;
    assign o_data_oe       = vdrv_ff | (in_wr & xfer);
    assign o_io_request_n  = ~((in_rd | in_wr) & pio &
                             on_win(tick_ff, last, erl[`BTS_E_IO], 1'b0));
    assign o_mem_request_n = ~((in_rd | in_wr) & ~pio &
                             on_win(tick_ff, last, erl[`BTS_E_MEM], 1'b0));
    assign o_rd_n          = ~(in_rd & on_win(tick_ff, last, erl[`BTS_E_RD], 1'b1));
    assign o_wr_n          = ~(in_wr & on_win(tick_ff, last, erl[`BTS_E_WR], 1'b1));
    assign o_bus_request_line_oe = breq_ff;
    assign o_bus_grant_out_n = bai_s | breq_ff;
    assign o_irq_chain_out = iei_s & ~ius_ff;
    assign o_int_oe        = (ip_ff & iei_s & ~ius_ff) |
                             (pls_ff & breq_ff & mst_ff);
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~acc_ff;

    // ======================================================
    // two-flop pin synchroniser and bus handshake
    always @(posedge i_clk) begin
        if (i_srst) begin
            sy1_ff   <= 15'h7e00;
            sy2_ff   <= 15'h7e00;
            acc_ff   <= 1'b0;
            o_avs_readdata <= 32'h0;
        end else begin
            sy1_ff <= {i_wait_n, i_irq_chain_in, i_io_request_n,
                       i_opcode_fetch_cycle_n, i_bus_request_line,
                       i_bus_grant_in_n, i_rdy, i_data};
            sy2_ff <= sy1_ff;
            acc_ff <= (i_avs_read | i_avs_write) & ~acc_ff;
            // read data captured in the wait cycle
            case (i_avs_address)
                `BTS_CTRL:  o_avs_readdata <= {24'h0, ctrl_ff};
                `BTS_STA:   o_avs_readdata <= {16'h0, sa_ff};
                `BTS_STB:   o_avs_readdata <= {16'h0, sb_ff};
                `BTS_LEN:   o_avs_readdata <= {16'h0, len_ff};
                `BTS_MATCH: o_avs_readdata <= {16'h0, mask_ff, mbyte_ff};
                `BTS_TIME:  o_avs_readdata <= {14'h0, tim_ff};
                `BTS_INTC:  o_avs_readdata <= {8'h0, intc_ff};
                `BTS_STAT:  o_avs_readdata <= {26'h0, mst_ff, en_ff, ip_ff,
                                               mat_ff, eob_ff, rdy_act};
                `BTS_CNT:   o_avs_readdata <= {16'h0, cnt_ff};
                `BTS_CURA:  o_avs_readdata <= {16'h0, ca_ff};
                `BTS_CURB:  o_avs_readdata <= {16'h0, cb_ff};
                default:    o_avs_readdata <= 32'h0;
            endcase
        end
    end

    // ======================================================
    // registers, sequencer, status and interrupts
    always @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_ff  <= 8'h0;
            sa_ff    <= 16'h0;
            sb_ff    <= 16'h0;
            len_ff   <= 16'h0;
            mbyte_ff <= 8'h0;
            mask_ff  <= 8'h0;
            tim_ff   <= 18'h0;
            intc_ff  <= 24'h0;
            ca_ff    <= 16'h0;
            cb_ff    <= 16'h0;
            cnt_ff   <= 16'h0;
            st_ff    <= S_IDLE;
            tick_ff  <= 4'h0;
            byte_ff  <= 8'h0;
            en_ff    <= 1'b0;
            breq_ff  <= 1'b0;
            mst_ff   <= 1'b0;
            eob_ff   <= 1'b0;
            mat_ff   <= 1'b0;
            cmp_ff   <= 1'b0;
            ip_ff    <= 1'b0;
            ius_ff   <= 1'b0;
            cause_ff <= 2'h0;
            vdrv_ff  <= 1'b0;
            ack_d_ff <= 1'b0;
            m1_d_ff  <= 1'b1;
            ed_ff    <= 1'b0;
            pcnt_ff  <= 8'h0;
            pls_ff   <= 1'b0;
        end else begin
            pls_ff   <= 1'b0;
            ack_d_ff <= ack;
            m1_d_ff  <= m1_s;
            // acknowledge drives vector, clears pending
            if (ack & ~ack_d_ff & ip_ff & iei_s) begin
                vdrv_ff <= 1'b1;
                ius_ff  <= 1'b1;
                ip_ff   <= 1'b0;
            end else if (~ack) begin
                vdrv_ff <= 1'b0;
            end
            // return opcode pair ends service
            if (m1_s & ~m1_d_ff & io_request_s) begin
                ed_ff <= (data_s == `BTS_OP_ED);
                if (ed_ff & (data_s == `BTS_OP_4D))
                    ius_ff <= 1'b0;
            end
            // host writes, start buffers leave counters alone
            if (wr_ok) begin
                en_ff <= 1'b0;
                case (i_avs_address)
                    `BTS_CTRL:  ctrl_ff <= i_avs_writedata[7:0];
                    `BTS_STA:   sa_ff <= i_avs_writedata[15:0];
                    `BTS_STB:   sb_ff <= i_avs_writedata[15:0];
                    `BTS_LEN:   len_ff <= i_avs_writedata[15:0];
                    `BTS_MATCH: {mask_ff, mbyte_ff} <= i_avs_writedata[15:0];
                    `BTS_TIME:  tim_ff <= i_avs_writedata[17:0];
                    `BTS_INTC:  intc_ff <= i_avs_writedata[23:0];
                    `BTS_CMD: begin
                        // every other command, and any other register write, disables
                        if (cmd == `BTS_K_EN)
                            en_ff <= 1'b1;
                        if (cmd == `BTS_K_LOAD) begin
                            ca_ff   <= sa_ff;
                            cb_ff   <= sb_ff;
                            cnt_ff  <= 16'h0;
                            pcnt_ff <= intc_ff[`BTS_I_OFS];
                        end
                        if (cmd == `BTS_K_CONT)
                            cnt_ff <= 16'h0;
                        if (cmd == `BTS_K_CLR || cmd == `BTS_K_RST) begin
                            eob_ff <= 1'b0;
                            mat_ff <= 1'b0;
                            ip_ff  <= 1'b0;
                            cmp_ff <= 1'b0;
                        end
                        if (cmd == `BTS_K_RST)
                            ius_ff <= 1'b0;
                    end
                    default: ;
                endcase
            end
            // sequencer
            case (st_ff)
                S_IDLE: begin
                    if (en_ff & rdy_act & brq_s & ~wr_ok) begin
                        breq_ff <= 1'b1;
                        st_ff   <= S_REQ;
                        if (intc_ff[`BTS_I_RDY]) begin
                            ip_ff    <= 1'b1;
                            cause_ff <= `BTS_CA_RDY;
                        end
                    end
                end
                S_REQ: begin
                    if (~en_ff | wr_ok) begin
                        breq_ff <= 1'b0;
                        st_ff   <= S_IDLE;
                    end else if (~bai_s) begin
                        mst_ff  <= 1'b1;
                        tick_ff <= 4'h0;
                        st_ff   <= S_RD;
                    end
                end
                S_RD, S_WR: begin
                    if (cyc_end) begin
                        tick_ff <= 4'h0;
                        if (in_rd) begin
                            byte_ff <= data_s;
                            if (atob)
                                ca_ff <= step(ca_ff, tim_ff[`BTS_T_AMA]);
                            else
                                cb_ff <= step(cb_ff, tim_ff[`BTS_T_AMB]);
                            // read byte goes on to a write only when xfer is set
                            st_ff <= xfer ? S_WR : S_NXT;
                        end else begin
                            if (atob)
                                cb_ff <= step(cb_ff, tim_ff[`BTS_T_AMB]);
                            else
                                ca_ff <= step(ca_ff, tim_ff[`BTS_T_AMA]);
                            st_ff <= S_NXT;
                        end
                    end else if (~held) begin
                        tick_ff <= tick_ff + 4'h1;
                    end
                end
                S_NXT: begin
                    // one byte behind: report prior compare
                    cmp_ff  <= srch & ((byte_ff ^ mbyte_ff) & ~mask_ff) == 8'h00;
                    cnt_ff  <= cnt_ff + 16'h0001;
                    pcnt_ff <= pcnt_ff + 8'h01;
                    if (intc_ff[`BTS_I_PLS] & (pcnt_ff == `BTS_PL_TOP))
                        pls_ff <= 1'b1;
                    if (cmp_ff) begin
                        mat_ff <= 1'b1;
                        if (intc_ff[`BTS_I_MAT]) begin
                            ip_ff    <= 1'b1;
                            cause_ff <= `BTS_CA_MAT;
                        end
                        if (~xfer)
                            en_ff <= 1'b0;
                    end
                    if (eob_now) begin
                        eob_ff <= 1'b1;
                        if (intc_ff[`BTS_I_EOB]) begin
                            ip_ff    <= 1'b1;
                            cause_ff <= `BTS_CA_EOB;
                        end
                        if (ctrl_ff[`BTS_C_AUTO]) begin
                            ca_ff  <= sa_ff;
                            cb_ff  <= sb_ff;
                            cnt_ff <= 16'h0;
                        end else begin
                            en_ff <= 1'b0;
                        end
                    end
                    if ((eob_now & ~ctrl_ff[`BTS_C_AUTO]) | (cmp_ff & ~xfer) |
                        (ctrl_ff[`BTS_C_MODE] == `BTS_M_BYTE))
                        st_ff <= S_REL;
                    else if (rdy_act)
                        st_ff <= S_RD;
                    else if (ctrl_ff[`BTS_C_MODE] == `BTS_M_BRST)
                        st_ff <= S_REL;
                    else
                        st_ff <= S_PAU;
                end
                S_PAU: begin
                    if (~en_ff)
                        st_ff <= S_REL;
                    else if (rdy_act)
                        st_ff <= S_RD;
                end
                S_REL: begin
                    mst_ff  <= 1'b0;
                    breq_ff <= 1'b0;
                    st_ff   <= S_IDLE;
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end
endmodule // btsdma_core
`default_nettype wire

// >>> rtl/btsdma_regs.vh
// register map, field positions and command codes of the dma engine
// assumes word addressing on the avalon-mm slave port
`ifndef BTSDMA_REGS_VH
`define BTSDMA_REGS_VH
// ======================================================
// register word offsets
`define BTS_CTRL   4'h0
`define BTS_CMD    4'h1
`define BTS_STA    4'h2
`define BTS_STB    4'h3
`define BTS_LEN    4'h4
`define BTS_MATCH  4'h5
`define BTS_TIME   4'h6
`define BTS_INTC   4'h7
`define BTS_STAT   4'h8
`define BTS_CNT    4'h9
`define BTS_CURA   4'ha
`define BTS_CURB   4'hb
// ======================================================
// control fields
`define BTS_C_XFER 0
`define BTS_C_SRCH 1
`define BTS_C_MODE 3:2
`define BTS_C_ATOB 4
`define BTS_C_AUTO 5
`define BTS_C_RDHI 6
`define BTS_M_BYTE 2'h0
`define BTS_M_BRST 2'h1
// ======================================================
// timing fields: cycle length, early ends, io select, count rule
`define BTS_T_CYA  1:0
`define BTS_T_CYB  3:2
`define BTS_T_ERA  7:4
`define BTS_T_ERB  11:8
`define BTS_T_IOA  12
`define BTS_T_IOB  13
`define BTS_T_AMA  15:14
`define BTS_T_AMB  17:16
`define BTS_A_INC  2'h1
`define BTS_A_FIX  2'h2
`define BTS_E_IO   0
`define BTS_E_MEM  1
`define BTS_E_RD   2
`define BTS_E_WR   3
// ======================================================
// interrupt control fields and causes
`define BTS_I_RDY  0
`define BTS_I_MAT  1
`define BTS_I_EOB  2
`define BTS_I_SAV  3
`define BTS_I_PLS  4
`define BTS_I_VEC  15:8
`define BTS_I_OFS  23:16
`define BTS_CA_RDY 2'h0
`define BTS_CA_MAT 2'h1
`define BTS_CA_EOB 2'h2
// ======================================================
// commands and opcodes
`define BTS_K_EN   8'h87
`define BTS_K_RST  8'hc3
`define BTS_K_LOAD 8'hcf
`define BTS_K_CONT 8'hd3
`define BTS_K_CLR  8'h8b
`define BTS_OP_ED  8'hed
`define BTS_OP_4D  8'h4d
`define BTS_PL_TOP 8'hff
`define BTS_WT_TK  4'h2
`endif

// >>> verification/btsdma_bus_model.sv
// memory and cpu stand-in on the far side of the dma system bus
// assumes active low strobes and a pulled-up request line
`timescale 1ns/1ps
`default_nettype none
module btsdma_bus_model (
    input  wire logic        i_clk,      // system clock
    input  wire logic [15:0] i_addr,     // address from dma
    input  wire logic        i_rd_n,     // read strobe
    input  wire logic        i_wr_n,     // write strobe
    input  wire logic        i_mem_n,    // memory request
    input  wire logic [7:0]  i_wdata,    // data from dma
    input  wire logic        i_wdata_oe, // dma drives data
    input  wire logic        i_req_oe,   // dma pulls request line
    output logic      [7:0]  o_rdata,    // data to dma
    output logic             o_grant_n   // grant to dma
);
    logic [7:0] mem [0:255];
    logic [7:0] last_ff;
    // ======================================================
    // preset memory with a known pattern
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
        last_ff = 8'h00;
        o_grant_n = 1'b1;
    end
    // grant follows the request a clock later; writes land in memory
    always @(posedge i_clk) begin
        o_grant_n <= !i_req_oe;
        if (!i_rd_n && !i_mem_n) last_ff <= mem[i_addr[7:0]];
        if (!i_wr_n && !i_mem_n && i_wdata_oe) mem[i_addr[7:0]] <= i_wdata;
    end
    // a released data bus shows the inverse of the last byte
    assign o_rdata = (!i_rd_n && !i_mem_n) ? mem[i_addr[7:0]] : ~last_ff;
endmodule // btsdma_bus_model
`default_nettype wire

// >>> verification/btsdma_core_checker.sv
// port-level assertions for the dma engine
// assumes default settings of two-clock strobes and no wait states
`timescale 1ns/1ps
`default_nettype none
module btsdma_core_checker (
    input wire logic i_clk,                 // clock
    input wire logic i_srst,                // sync reset
    input wire logic i_avs_read,            // register read
    input wire logic i_avs_write,           // register write
    input wire logic o_avs_waitrequest,     // stall
    input wire logic o_addr_oe,             // address drive
    input wire logic o_ctl_oe,              // strobe drive
    input wire logic o_rd_n,                // read strobe
    input wire logic o_wr_n,                // write strobe
    input wire logic o_mem_request_n,       // memory request
    input wire logic o_io_request_n,        // io request
    input wire logic o_bus_request_line_oe, // request pull
    input wire logic o_bus_grant_out_n,     // grant out
    input wire logic i_bus_grant_in_n       // grant in
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // ======================================================
    // strobe shapes
    sequence rd_pulse;
        !o_rd_n [*2] ##1 o_rd_n;
    endsequence
    sequence wr_pulse;
        !o_wr_n [*2] ##1 o_wr_n;
    endsequence
    idle_strobe_a: assert property (!o_ctl_oe |-> o_rd_n && o_wr_n && o_mem_request_n)
        else $error("strobe active off bus");
    oe_pair_a: assert property (o_addr_oe == o_ctl_oe)
        else $error("address and strobe enables differ");
    rd_wr_apart_a: assert property (!(!o_rd_n && !o_wr_n))
        else $error("read and write strobes together");
    rd_qual_a: assert property (!o_rd_n |-> o_mem_request_n ^ o_io_request_n)
        else $error("read without one request");
    rd_width_a: assert property ($fell(o_rd_n) |-> rd_pulse)
        else $error("read strobe width wrong");
    wr_width_a: assert property ($fell(o_wr_n) |-> wr_pulse)
        else $error("write strobe width wrong");
    grant_first_a: assert property ($rose(o_addr_oe) |-> $past(!i_bus_grant_in_n))
        else $error("master without grant");
    grant_block_a: assert property (
        o_bus_grant_out_n == ($past(i_bus_grant_in_n, 2) || o_bus_request_line_oe))
        else $error("grant passed while requesting");
    wait_one_a: assert property ($rose(i_avs_read || i_avs_write) |->
        o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("register access wait wrong");
endmodule // btsdma_core_checker
bind btsdma_core btsdma_core_checker u_chk (.i_clk(i_clk), .i_srst(i_srst),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .o_addr_oe(o_addr_oe), .o_ctl_oe(o_ctl_oe), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
    .o_mem_request_n(o_mem_request_n), .o_io_request_n(o_io_request_n),
    .o_bus_request_line_oe(o_bus_request_line_oe), .o_bus_grant_out_n(o_bus_grant_out_n),
    .i_bus_grant_in_n(i_bus_grant_in_n));
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench: programs the dma over avalon-mm and checks memory
// assumes the bus model grants buses and holds a preset pattern
`timescale 1ns/1ps
`default_nettype none
`include "btsdma_regs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module testbench;
    logic        i_clk, i_srst, rd, wr, rdy;
    logic [3:0]  adr;
    logic [31:0] wd, rdat, q;
    wire  [15:0] sa;
    wire  [7:0]  di, dout;
    wire         wq, aoe, doe, mq, iq, rn, wn, coe, rqoe, gn, ico, ioe;
    int          bad_count, n_tests, k;
    btsdma_core i_btsdma_core (.i_clk(i_clk), .i_srst(i_srst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq), .o_addr(sa), .o_addr_oe(aoe), .i_data(di), .o_data(dout),
        .o_data_oe(doe), .o_mem_request_n(mq), .o_io_request_n(iq), .o_rd_n(rn), .o_wr_n(wn),
        .o_ctl_oe(coe), .i_io_request_n(1'b1), .i_opcode_fetch_cycle_n(1'b1), .i_rdy(rdy),
        .i_wait_n(1'b1), .i_bus_request_line(!rqoe), .o_bus_request_line_oe(rqoe),
        .i_bus_grant_in_n(gn), .o_bus_grant_out_n(), .i_irq_chain_in(1'b1),
        .o_irq_chain_out(ico), .o_int_oe(ioe));
    btsdma_bus_model u_mem (.i_clk(i_clk), .i_addr(sa), .i_rd_n(rn), .i_wr_n(wn),
        .i_mem_n(mq), .i_wdata(dout), .i_wdata_oe(doe), .i_req_oe(rqoe), .o_rdata(di),
        .o_grant_n(gn));
    // ======================================================
    // avalon access: hold until waitrequest is sampled low
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        @(posedge i_clk);
        // only the watchdog ends a wait that never gets its answer
        while (wq !== 1'b0) @(posedge i_clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // program a four-byte block from 8'h10 and enable it
    task automatic prog(input logic [31:0] ctl, input logic [7:0] dst, input logic [15:0] mm);
        acc(1, `BTS_CTRL, ctl);
        acc(1, `BTS_STA, 32'h10);
        acc(1, `BTS_STB, {24'h0, dst});
        acc(1, `BTS_LEN, 32'h3);
        acc(1, `BTS_MATCH, {16'h0, mm});
        acc(1, `BTS_TIME, 32'h14000);
        acc(1, `BTS_CMD, 32'h8b);
        acc(1, `BTS_CMD, 32'hcf);
        acc(1, `BTS_CMD, 32'h87);
    endtask
    // poll status until the block ends or a search stops
    task automatic fin(input logic [31:0] ctl);
        for (k = 0; k < 300; k++) begin
            acc(0, `BTS_STAT, 0);
            if (q[5] === 1'b0 && (q[1] === 1'b1 || (q[2] === 1'b1 && !ctl[0]))) break;
        end
    endtask
    task automatic run(input logic [31:0] ctl, input logic [7:0] dst, input logic [15:0] mm);
        prog(ctl, dst, mm);
        fin(ctl);
    endtask
    // destination must hold the source pattern
    task automatic chk_dst(input logic [7:0] dst);
        for (int i = 0; i < 4; i++) `CHK(u_mem.mem[dst + i], 8'(8'h10 + i) ^ 8'h5a)
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ======================================================
    // clock, watchdog, main sequence
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        repeat (30000) @(posedge i_clk);
        bad_count++;
        close_out;
    end
    initial begin
        {i_srst, rd, wr, rdy, adr, wd, bad_count, n_tests} = '0;
        i_srst = 1'b1;
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        `CHK(aoe, 1'b0)
        acc(0, 4'hf, 0);
        `CHK(q, 32'h0)
        acc(1, `BTS_CTRL, 32'h51);
        acc(1, `BTS_CMD, 32'h87);
        acc(0, `BTS_STAT, 0);
        `CHK(q[4], 1'b1)
        acc(1, `BTS_CMD, 32'hbf);
        acc(0, `BTS_STAT, 0);
        `CHK(q[4], 1'b0)
        acc(1, `BTS_CMD, 32'h87);
        acc(1, `BTS_LEN, 32'h3);
        acc(0, `BTS_STAT, 0);
        `CHK(q[4], 1'b0)
        rdy <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            run(32'h51 | (m << 2), 8'h80 + 8'(m * 8), 16'h0);
            `CHK(q[1], 1'b1)
            chk_dst(8'h80 + 8'(m * 8));
        end
        // ready drops mid block: burst releases, continuous pauses on the bus
        for (int m = 1; m < 3; m++) begin
            prog(32'h51 | (m << 2), 8'he0 + 8'(m * 8), 16'h0);
            for (k = 0; k < 300 && q[5] !== 1'b1; k++) acc(0, `BTS_STAT, 0);
            rdy <= 1'b0;
            repeat (40) @(posedge i_clk);
            acc(0, `BTS_STAT, 0);
            `CHK(q[5:4], {m == 2, 1'b1})
            rdy <= 1'b1;
            fin(32'h51);
            `CHK(q[1], 1'b1)
            chk_dst(8'he0 + 8'(m * 8));
        end
        run(32'h53, 8'hb0, 16'hff00);
        `CHK(q[2], 1'b1)
        chk_dst(8'hb0);
        run(32'h52, 8'hc0, 16'h004b);
        `CHK(q[2], 1'b1)
        `CHK(u_mem.mem[8'hc0], 8'hc0 ^ 8'h5a)
        run(32'h52, 8'hc0, 16'h00ff);
        `CHK(q[2:1], 2'b01)
        `CHK({ico, ioe}, 2'b10)
        close_out;
    end
endmodule // testbench
`default_nettype wire
